//--- verilog/lps_pkg.sv
// Functional notes
// - Ambient mode bit 1: 0 standby, 1 active; standby after reset.
// - Register access works in standby and active alike.
// - No ambient measurement while ambient channel is in standby.
// - Ambient gain bits 4:3 pick 1, 0.5, 0.01, 0.005 lux per count.
// - Writing 1 to ambient bit 2 starts soft reset; bit reads 0 after.
// - Proximity mode bit 1: 0 standby, 1 active; standby after reset.
// - Emitter frequency bits 7:5 pick 30 to 100 kHz, 10 kHz steps.
// - Emitter current bits 2:0 pick 5, 10, 20, 50, else 100 mA.
// - Pulse count register sets emitter pulses per proximity measurement.
// - Repeat code picks 12.5, 50, 70, 100, 200, 500, 1000, 2000 ms.
// - Repeat code 000 disables ambient measurement automatically.
// - Active proximity channel updates its result once per interval.
package lps_pkg;
    localparam logic [7:0] ADDR_AMB_CTRL = 8'h80;
    localparam logic [7:0] ADDR_PROX_CTRL = 8'h81;
    localparam logic [7:0] ADDR_EMIT_SETUP = 8'h82;
    localparam logic [7:0] ADDR_PULSE_CNT = 8'h83;
    localparam logic [7:0] ADDR_REPEAT = 8'h84;

    localparam logic [7:0] RST_AMB_CTRL = 8'h00;
    localparam logic [7:0] RST_PROX_CTRL = 8'h0C;
    localparam logic [7:0] RST_EMIT_SETUP = 8'h6B;
    localparam logic [7:0] RST_PULSE_CNT = 8'h7F;
    localparam logic [7:0] RST_REPEAT = 8'h03;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int MODE_BIT = 1;
    localparam int SRESET_BIT = 2;
    localparam int AGAIN_LSB = 3;
    localparam int FREQ_LSB = 5;
    localparam int CURR_LSB = 0;
    localparam int RATE_LSB = 0;

    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
    localparam int unsigned FREQ_BASE_KHZ = 30;
    localparam int unsigned FREQ_STEP_KHZ = 10;

    localparam int unsigned RPT_US_0 = 12500;
    localparam int unsigned RPT_US_1 = 50000;
    localparam int unsigned RPT_US_2 = 70000;
    localparam int unsigned RPT_US_3 = 100000;
    localparam int unsigned RPT_US_4 = 200000;
    localparam int unsigned RPT_US_5 = 500000;
    localparam int unsigned RPT_US_6 = 1000000;
    localparam int unsigned RPT_US_7 = 2000000;
    localparam int unsigned RPT_CYC_0 = RPT_US_0 * CLK_MHZ;
    localparam int unsigned RPT_CYC_1 = RPT_US_1 * CLK_MHZ;
    localparam int unsigned RPT_CYC_2 = RPT_US_2 * CLK_MHZ;
    localparam int unsigned RPT_CYC_3 = RPT_US_3 * CLK_MHZ;
    localparam int unsigned RPT_CYC_4 = RPT_US_4 * CLK_MHZ;
    localparam int unsigned RPT_CYC_5 = RPT_US_5 * CLK_MHZ;
    localparam int unsigned RPT_CYC_6 = RPT_US_6 * CLK_MHZ;
    localparam int unsigned RPT_CYC_7 = RPT_US_7 * CLK_MHZ;

    // Current in mA and scale in units of 0.005 lux per count
    localparam logic [6:0] CURR_MA_0 = 7'h05;
    localparam logic [6:0] CURR_MA_1 = 7'h0A;
    localparam logic [6:0] CURR_MA_2 = 7'h14;
    localparam logic [6:0] CURR_MA_3 = 7'h32;
    localparam logic [6:0] CURR_MA_HI = 7'h64;
    localparam logic [7:0] SCALE_0 = 8'hC8;
    localparam logic [7:0] SCALE_1 = 8'h64;
    localparam logic [7:0] SCALE_2 = 8'h02;
    localparam logic [7:0] SCALE_3 = 8'h01;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lps_req_t;

    typedef enum logic [1:0] {PX_IDLE, PX_WAIT, PX_BURST} lps_prox_state_t;
endpackage

//--- verilog/lps_ctrl.sv
`timescale 1ns/1ps
module lps_ctrl #(
    parameter int unsigned RPT_CYC_0 = lps_pkg::RPT_CYC_0,
    parameter int unsigned RPT_CYC_1 = lps_pkg::RPT_CYC_1,
    parameter int unsigned RPT_CYC_2 = lps_pkg::RPT_CYC_2,
    parameter int unsigned RPT_CYC_3 = lps_pkg::RPT_CYC_3,
    parameter int unsigned RPT_CYC_4 = lps_pkg::RPT_CYC_4,
    parameter int unsigned RPT_CYC_5 = lps_pkg::RPT_CYC_5,
    parameter int unsigned RPT_CYC_6 = lps_pkg::RPT_CYC_6,
    parameter int unsigned RPT_CYC_7 = lps_pkg::RPT_CYC_7
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic link_req_valid_in,
    input wire lps_pkg::lps_req_t link_req_in,
    output logic link_req_ready_out,
    output logic link_rsp_valid_out,
    output logic [7:0] link_rsp_data_out,
    output logic ambient_active_out,
    output logic [1:0] ambient_gain_out,
    output logic [7:0] ambient_scale_out,
    output logic proximity_active_out,
    output logic emitter_out,
    output logic [6:0] emitter_current_ma_out,
    output logic proximity_update_out,
    output logic soft_reset_out
);
    ////////////////////////////////////////////////////////////////
    // Link domain: request capture and answer
    lps_pkg::lps_req_t link_req_q;
    logic link_pend_q;
    logic link_tog_q;
    logic [2:0] ack_sync_q;
    logic ack_seen_q;
    logic ack_tog_q;
    logic [7:0] sys_rdata_q;
    logic ack_evt;

    assign link_req_ready_out = !link_pend_q;
    assign ack_evt = (ack_sync_q[1] == ack_sync_q[2]) && (ack_sync_q[2] != ack_seen_q);

    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
            ack_sync_q <= 3'h0;
        else
            ack_sync_q <= {ack_sync_q[1:0], ack_tog_q};
    end

    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            link_req_q <= '0;
            link_pend_q <= 1'b0;
            link_tog_q <= 1'b0;
            ack_seen_q <= 1'b0;
            link_rsp_valid_out <= 1'b0;
            link_rsp_data_out <= 8'h00;
        end
        else
        begin
            link_rsp_valid_out <= 1'b0;
            if (ack_evt)
            begin
                ack_seen_q <= ack_sync_q[2];
                link_pend_q <= 1'b0;
                link_rsp_valid_out <= 1'b1;
                link_rsp_data_out <= sys_rdata_q;
            end
            else if (link_req_valid_in && !link_pend_q)
            begin
                link_req_q <= link_req_in;
                link_pend_q <= 1'b1;
                link_tog_q <= !link_tog_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // System domain: request detection
    logic [2:0] req_sync_q;
    logic req_seen_q;
    logic req_evt;

    assign req_evt = (req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != req_seen_q);

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            req_sync_q <= 3'h0;
            req_seen_q <= 1'b0;
        end
        else
        begin
            req_sync_q <= {req_sync_q[1:0], link_tog_q};
            if (req_evt)
                req_seen_q <= req_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] amb_ctrl_q;
    logic [7:0] prox_ctrl_q;
    logic [7:0] emit_setup_q;
    logic [7:0] pulse_cnt_q;
    logic [7:0] repeat_q;
    logic wr_evt;
    logic sreset_d;

    assign wr_evt = req_evt && link_req_q.write;
    assign sreset_d = wr_evt && (link_req_q.addr == lps_pkg::ADDR_AMB_CTRL)
        && link_req_q.wdata[lps_pkg::SRESET_BIT];

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            amb_ctrl_q <= lps_pkg::RST_AMB_CTRL;
            prox_ctrl_q <= lps_pkg::RST_PROX_CTRL;
            emit_setup_q <= lps_pkg::RST_EMIT_SETUP;
            pulse_cnt_q <= lps_pkg::RST_PULSE_CNT;
            repeat_q <= lps_pkg::RST_REPEAT;
        end
        else if (sreset_d)
        begin
            amb_ctrl_q <= lps_pkg::RST_AMB_CTRL;
            prox_ctrl_q <= lps_pkg::RST_PROX_CTRL;
            emit_setup_q <= lps_pkg::RST_EMIT_SETUP;
            pulse_cnt_q <= lps_pkg::RST_PULSE_CNT;
            repeat_q <= lps_pkg::RST_REPEAT;
        end
        else if (wr_evt)
        begin
            // Writes accepted in any mode
            case (link_req_q.addr)
                lps_pkg::ADDR_AMB_CTRL: amb_ctrl_q <= link_req_q.wdata;
                lps_pkg::ADDR_PROX_CTRL: prox_ctrl_q <= link_req_q.wdata;
                lps_pkg::ADDR_EMIT_SETUP: emit_setup_q <= link_req_q.wdata;
                lps_pkg::ADDR_PULSE_CNT: pulse_cnt_q <= link_req_q.wdata;
                lps_pkg::ADDR_REPEAT: repeat_q <= link_req_q.wdata;
                default: amb_ctrl_q <= amb_ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            soft_reset_out <= 1'b0;
        else
            soft_reset_out <= sreset_d;
    end

    // Read data and answer toggle
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sys_rdata_q <= 8'h00;
            ack_tog_q <= 1'b0;
        end
        else if (req_evt)
        begin
            ack_tog_q <= !ack_tog_q;
            case (link_req_q.addr)
                lps_pkg::ADDR_AMB_CTRL: sys_rdata_q <= amb_ctrl_q;
                lps_pkg::ADDR_PROX_CTRL: sys_rdata_q <= prox_ctrl_q;
                lps_pkg::ADDR_EMIT_SETUP: sys_rdata_q <= emit_setup_q;
                lps_pkg::ADDR_PULSE_CNT: sys_rdata_q <= pulse_cnt_q;
                lps_pkg::ADDR_REPEAT: sys_rdata_q <= repeat_q;
                default: sys_rdata_q <= lps_pkg::UNMAPPED_READ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Decoding
    function automatic logic [31:0] rpt_cycles(input logic [2:0] code);
        case (code)
            3'h0: rpt_cycles = RPT_CYC_0;
            3'h1: rpt_cycles = RPT_CYC_1;
            3'h2: rpt_cycles = RPT_CYC_2;
            3'h3: rpt_cycles = RPT_CYC_3;
            3'h4: rpt_cycles = RPT_CYC_4;
            3'h5: rpt_cycles = RPT_CYC_5;
            3'h6: rpt_cycles = RPT_CYC_6;
            default: rpt_cycles = RPT_CYC_7;
        endcase
    endfunction

    function automatic logic [15:0] half_period(input logic [2:0] code);
        logic [31:0] khz;
        khz = lps_pkg::FREQ_BASE_KHZ + lps_pkg::FREQ_STEP_KHZ * 32'(code);
        half_period = 16'(lps_pkg::CLK_KHZ / (2 * khz));
    endfunction

    logic [2:0] rate_code;
    logic [2:0] freq_code;
    logic [2:0] curr_code;
    logic [1:0] gain_code;
    logic amb_on;
    logic prox_on;

    assign rate_code = repeat_q[lps_pkg::RATE_LSB +: 3];
    assign freq_code = emit_setup_q[lps_pkg::FREQ_LSB +: 3];
    assign curr_code = emit_setup_q[lps_pkg::CURR_LSB +: 3];
    assign gain_code = amb_ctrl_q[lps_pkg::AGAIN_LSB +: 2];
    // Fastest repeat rate forces the ambient channel off
    assign amb_on = amb_ctrl_q[lps_pkg::MODE_BIT] && (rate_code != 3'h0);
    assign prox_on = prox_ctrl_q[lps_pkg::MODE_BIT];

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ambient_active_out <= 1'b0;
            ambient_gain_out <= 2'h0;
            ambient_scale_out <= lps_pkg::SCALE_0;
            proximity_active_out <= 1'b0;
            emitter_current_ma_out <= lps_pkg::CURR_MA_3;
        end
        else
        begin
            ambient_active_out <= amb_on && !sreset_d;
            proximity_active_out <= prox_on && !sreset_d;
            ambient_gain_out <= gain_code;
            case (gain_code)
                2'h0: ambient_scale_out <= lps_pkg::SCALE_0;
                2'h1: ambient_scale_out <= lps_pkg::SCALE_1;
                2'h2: ambient_scale_out <= lps_pkg::SCALE_2;
                default: ambient_scale_out <= lps_pkg::SCALE_3;
            endcase
            case (curr_code)
                3'h0: emitter_current_ma_out <= lps_pkg::CURR_MA_0;
                3'h1: emitter_current_ma_out <= lps_pkg::CURR_MA_1;
                3'h2: emitter_current_ma_out <= lps_pkg::CURR_MA_2;
                3'h3: emitter_current_ma_out <= lps_pkg::CURR_MA_3;
                default: emitter_current_ma_out <= lps_pkg::CURR_MA_HI;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Proximity measurement sequencer
    lps_pkg::lps_prox_state_t px_state_q;
    logic [31:0] interval_q;
    logic [15:0] phase_q;
    logic [7:0] pulses_left_q;
    logic emit_q;
    logic interval_done;
    logic phase_done;

    assign interval_done = (interval_q >= rpt_cycles(rate_code) - 32'h1);
    assign phase_done = (phase_q >= half_period(freq_code) - 16'h1);

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            interval_q <= 32'h0;
        else if (!prox_on || sreset_d || px_state_q == lps_pkg::PX_IDLE || interval_done)
            interval_q <= 32'h0;
        else
            interval_q <= interval_q + 32'h1;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            px_state_q <= lps_pkg::PX_IDLE;
            phase_q <= 16'h0;
            pulses_left_q <= 8'h00;
            emit_q <= 1'b0;
            proximity_update_out <= 1'b0;
        end
        else
        begin
            proximity_update_out <= 1'b0;
            if (!prox_on || sreset_d)
            begin
                px_state_q <= lps_pkg::PX_IDLE;
                emit_q <= 1'b0;
                phase_q <= 16'h0;
            end
            else
            begin
                case (px_state_q)
                    lps_pkg::PX_IDLE:
                        px_state_q <= lps_pkg::PX_WAIT;
                    lps_pkg::PX_WAIT:
                        if (interval_done)
                        begin
                            pulses_left_q <= pulse_cnt_q;
                            phase_q <= 16'h0;
                            emit_q <= 1'b0;
                            px_state_q <= lps_pkg::PX_BURST;
                        end
                    lps_pkg::PX_BURST:
                        if (pulses_left_q == 8'h00 && !emit_q)
                        begin
                            proximity_update_out <= 1'b1;
                            px_state_q <= lps_pkg::PX_WAIT;
                        end
                        else if (phase_done)
                        begin
                            phase_q <= 16'h0;
                            emit_q <= !emit_q;
                            if (!emit_q)
                                pulses_left_q <= pulses_left_q - 8'h01;
                        end
                        else
                            phase_q <= phase_q + 16'h1;
                    default:
                        px_state_q <= lps_pkg::PX_IDLE;
                endcase
            end
        end
    end

    assign emitter_out = emit_q;
endmodule

//--- tb/lps_ctrl_chk.sv
`timescale 1ns/1ps
module lps_ctrl_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic link_req_valid_in,
    input wire logic link_req_ready_out,
    input wire logic link_rsp_valid_out,
    input wire logic [1:0] ambient_gain_out,
    input wire logic [7:0] ambient_scale_out,
    input wire logic ambient_active_out,
    input wire logic proximity_active_out,
    input wire logic emitter_out,
    input wire logic [6:0] emitter_current_ma_out,
    input wire logic proximity_update_out,
    input wire logic soft_reset_out
);
    sequence s_take;
        link_req_valid_in && link_req_ready_out;
    endsequence
    sequence s_idle;
        !proximity_active_out && !$past(proximity_active_out);
    endsequence
    a_take_busy: assert property (@(posedge link_clk_in) disable iff (rst_in)
        s_take |=> !link_req_ready_out) else $error("ready high after take");
    a_take_answer: assert property (@(posedge link_clk_in) disable iff (rst_in)
        s_take |-> ##[2:24] link_rsp_valid_out) else $error("no answer");
    a_rsp_pulse: assert property (@(posedge link_clk_in) disable iff (rst_in)
        link_rsp_valid_out |=> !link_rsp_valid_out) else $error("answer too long");
    a_scale_gain: assert property (@(posedge clock_in) disable iff (rst_in)
        ambient_scale_out == (ambient_gain_out == 2'h0 ? lps_pkg::SCALE_0 :
        ambient_gain_out == 2'h1 ? lps_pkg::SCALE_1 :
        ambient_gain_out == 2'h2 ? lps_pkg::SCALE_2 : lps_pkg::SCALE_3))
        else $error("scale wrong");
    a_current_legal: assert property (@(posedge clock_in) disable iff (rst_in)
        emitter_current_ma_out inside {7'h05, 7'h0A, 7'h14, 7'h32, 7'h64})
        else $error("current illegal");
    a_emit_standby: assert property (@(posedge clock_in) disable iff (rst_in)
        s_idle |-> !emitter_out) else $error("emitter in standby");
    a_upd_standby: assert property (@(posedge clock_in) disable iff (rst_in)
        s_idle |-> !proximity_update_out) else $error("update in standby");
    a_upd_pulse: assert property (@(posedge clock_in) disable iff (rst_in)
        proximity_update_out |=> !proximity_update_out) else $error("update long");
    a_soft_idle: assert property (@(posedge clock_in) disable iff (rst_in)
        soft_reset_out |=> (!ambient_active_out && !proximity_active_out)[*2])
        else $error("active after soft reset");
    a_emit_width: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(emitter_out) |=> (emitter_out || !proximity_active_out)[*8])
        else $error("pulse too short");
endmodule
bind lps_ctrl lps_ctrl_chk u_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .link_clk_in(link_clk_in),
    .link_req_valid_in(link_req_valid_in),
    .link_req_ready_out(link_req_ready_out),
    .link_rsp_valid_out(link_rsp_valid_out),
    .ambient_gain_out(ambient_gain_out),
    .ambient_scale_out(ambient_scale_out),
    .ambient_active_out(ambient_active_out),
    .proximity_active_out(proximity_active_out),
    .emitter_out(emitter_out),
    .emitter_current_ma_out(emitter_current_ma_out),
    .proximity_update_out(proximity_update_out),
    .soft_reset_out(soft_reset_out)
);

//--- tb/lps_host_model.sv
`timescale 1ns/1ps
module lps_host_model (
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic rsp_valid_in,
    output logic req_valid_out,
    output lps_pkg::lps_req_t req_out
);
    initial
    begin
        req_valid_out = 1'b0;
        req_out = '0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        int n;
        v = d;
        case (a)
            lps_pkg::ADDR_AMB_CTRL: v = d & 8'h1E;
            lps_pkg::ADDR_PROX_CTRL: v = (d & 8'h02) | 8'h0C;
            lps_pkg::ADDR_EMIT_SETUP: v = (d & 8'hE7) | 8'h08;
            lps_pkg::ADDR_REPEAT: v = d & 8'h07;
            default: ;
        endcase
        @(negedge clk_in);
        req_out = '{write: wr, addr: a, wdata: v};
        req_valid_out = 1'b1;
        while (ready_in !== 1'b1)
            @(negedge clk_in);
        @(posedge clk_in);
        @(negedge clk_in);
        req_valid_out = 1'b0;
        // Released lines show inverse
        req_out = lps_pkg::lps_req_t'(~req_out);
        n = 0;
        while (rsp_valid_in !== 1'b1 && n < 64)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask
endmodule

//--- tb/tb_lps_ctrl.sv
`timescale 1ns/1ps
module tb_lps_ctrl;
    // Intervals from repeat code 1 up long enough to hold the longest burst
    localparam int unsigned RB = 1600;
    localparam logic [7:0] RST_TAB [5] = '{lps_pkg::RST_AMB_CTRL, lps_pkg::RST_PROX_CTRL,
        lps_pkg::RST_EMIT_SETUP, lps_pkg::RST_PULSE_CNT, lps_pkg::RST_REPEAT};
    localparam logic [7:0] SC [4] = '{lps_pkg::SCALE_0, lps_pkg::SCALE_1,
        lps_pkg::SCALE_2, lps_pkg::SCALE_3};
    localparam logic [6:0] CUR [4] = '{lps_pkg::CURR_MA_0, lps_pkg::CURR_MA_1,
        lps_pkg::CURR_MA_2, lps_pkg::CURR_MA_3};
    logic clock_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_v, rdy, rsp_v, amb_act, prx_act, emit, upd, srst, emit_d;
    lps_pkg::lps_req_t req;
    logic [7:0] rsp_d, scale;
    logic [1:0] gain;
    logic [6:0] cur;
    logic [7:0] shadow [5];
    logic [7:0] exp_q [$];
    int n_mismatch = 0;
    int compares = 0;
    int n_upd = 0, cyc = 0, rises = 0, exp_n = 1, exp_per = 0, half, f;
    int hi_len = 0, n_srst = 0;
    always #12.5 clock_in = ~clock_in;
    initial
    begin
        #7;
        forever #24 link_clk_in = ~link_clk_in;
    end
    lps_ctrl #(.RPT_CYC_0(RB), .RPT_CYC_1(RB * 2), .RPT_CYC_2(RB * 3), .RPT_CYC_3(RB * 4),
        .RPT_CYC_4(RB * 5), .RPT_CYC_5(RB * 6), .RPT_CYC_6(RB * 7), .RPT_CYC_7(RB * 8)) dut (
        .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
        .link_req_valid_in(req_v), .link_req_in(req), .link_req_ready_out(rdy),
        .link_rsp_valid_out(rsp_v), .link_rsp_data_out(rsp_d), .ambient_active_out(amb_act),
        .ambient_gain_out(gain), .ambient_scale_out(scale), .proximity_active_out(prx_act),
        .emitter_out(emit), .emitter_current_ma_out(cur), .proximity_update_out(upd),
        .soft_reset_out(srst));
    lps_host_model host (.clk_in(link_clk_in), .ready_in(rdy), .rsp_valid_in(rsp_v),
        .req_valid_out(req_v), .req_out(req));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        check("pending answers", exp_q.size(), 0);
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic m;
        m = a >= 8'h80 && a <= 8'h84;
        exp_q.push_back(m ? shadow[a[2:0]] : lps_pkg::UNMAPPED_READ);
        if (wr && a == lps_pkg::ADDR_AMB_CTRL && d[2])
            shadow = RST_TAB;
        else if (wr && m)
            shadow[a[2:0]] = d;
        host.xfer(wr, a, d);
        repeat (3) @(negedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(negedge link_clk_in)
        if (rsp_v === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("answer count", 1, 0);
            else
                check("answer data", rsp_d, exp_q.pop_front());
        end
    always @(negedge clock_in)
    begin
        cyc++;
        if (emit === 1'b1 && emit_d !== 1'b1)
            rises++;
        if (emit === 1'b1)
            hi_len++;
        else
        begin
            if (emit_d === 1'b1 && prx_act === 1'b1)
                check("high width", hi_len, half);
            hi_len = 0;
        end
        emit_d = emit;
        if (srst === 1'b1)
            n_srst++;
        if (upd === 1'b1)
        begin
            if (n_upd > 0)
            begin
                check("pulses", rises, exp_n);
                check("period", cyc, exp_per);
            end
            n_upd++;
            cyc = 0;
            rises = 0;
        end
    end
    initial
    begin
        #1500000;
        n_mismatch++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(69));
        shadow = RST_TAB;
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clock_in);
        check("scale", scale, lps_pkg::SCALE_0);
        check("current", cur, lps_pkg::CURR_MA_3);
        check("active", {amb_act, prx_act}, 0);
        for (int i = 0; i < 6; i++)
            rw(1'b0, 8'h80 + i[7:0], 8'h00);
        for (int g = 0; g < 4; g++)
        begin
            rw(1'b1, lps_pkg::ADDR_AMB_CTRL, {3'h0, g[1:0], 3'h0});
            check("gain", gain, g[1:0]);
            check("scale", scale, SC[g]);
        end
        for (int c = 0; c < 8; c++)
        begin
            rw(1'b1, lps_pkg::ADDR_EMIT_SETUP, {3'h7, 2'h1, c[2:0]});
            check("current", cur, c < 4 ? CUR[c] : lps_pkg::CURR_MA_HI);
        end
        rw(1'b1, lps_pkg::ADDR_REPEAT, 8'h00);
        rw(1'b1, lps_pkg::ADDR_AMB_CTRL, 8'h02);
        check("ambient rate0", amb_act, 0);
        rw(1'b1, lps_pkg::ADDR_REPEAT, 8'h03);
        check("ambient on", amb_act, 1);
        rw(1'b1, lps_pkg::ADDR_AMB_CTRL, 8'h00);
        check("ambient off", amb_act, 0);
        // Exact half periods only: 40 or 100 kHz
        f = ($urandom % 2) ? 7 : 1;
        half = 20000 / (30 + 10 * f);
        exp_n = 1 + $urandom % 3;
        exp_per = RB * 2;
        rw(1'b1, lps_pkg::ADDR_EMIT_SETUP, {f[2:0], 2'h1, 3'h3});
        rw(1'b1, lps_pkg::ADDR_PULSE_CNT, exp_n[7:0]);
        rw(1'b1, lps_pkg::ADDR_REPEAT, 8'h01);
        n_upd = 0;
        rw(1'b1, lps_pkg::ADDR_PROX_CTRL, 8'h0E);
        for (int t = 0; t < 30000 && n_upd < 4; t++)
            @(negedge clock_in);
        check("updates", n_upd >= 4, 1);
        rw(1'b0, lps_pkg::ADDR_PULSE_CNT, 8'h00);
        rw(1'b1, lps_pkg::ADDR_AMB_CTRL, 8'h06);
        check("active", {amb_act, prx_act}, 0);
        for (int i = 0; i < 5; i++)
            rw(1'b0, 8'h80 + i[7:0], 8'h00);
        check("soft reset pulses", n_srst, 1);
        close_out();
    end
endmodule
